// [hdl/symmetric_pwm_timer.sv]
// Dual-slope symmetric PWM timer with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none

module symmetric_pwm_timer
	import pwm_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int WIDTH = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic pin_a,
	output logic pin_a_oe,
	output logic pin_b,
	output logic pin_b_oe
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic [7:0] waveform_output_ctrl_a;
	logic [7:0] waveform_ctrl_b;
	logic [WIDTH-1:0] count_value;
	logic [WIDTH-1:0] compare_a_value;
	logic [WIDTH-1:0] compare_b_value;
	logic [WIDTH-1:0] capture_top_value;
	logic [7:0] flags;
	logic [3:0] port_ctrl;
	dir_t dir;
	logic [9:0] pre_count;
	logic aw_held;
	logic w_held;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;

	function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// ------------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------------
	wire logic [3:0] waveform_mode_sel;
	wire logic [1:0] output_mode_sel_a;
	wire logic [1:0] output_mode_sel_b;
	wire logic [2:0] clock_sel;
	wire logic pfc_mode;
	wire logic toggle_ok_a;

	assign waveform_mode_sel = {waveform_ctrl_b[CTRLB_WGM_HI_LSB +: 2],
		waveform_output_ctrl_a[CTRLA_WGM_LO_LSB +: 2]};
	assign output_mode_sel_a = waveform_output_ctrl_a[CTRLA_MODE_A_LSB +: 2];
	assign output_mode_sel_b = waveform_output_ctrl_a[CTRLA_MODE_B_LSB +: 2];
	assign clock_sel = waveform_ctrl_b[CTRLB_CS_LSB +: 3];
	assign pfc_mode = (waveform_mode_sel == WGM_PFC_CAP_TOP) ||
		(waveform_mode_sel == WGM_PFC_CMP_TOP);
	assign toggle_ok_a = (waveform_mode_sel == WGM_PFC_CMP_TOP) ||
		(waveform_mode_sel == WGM_PC_CMP_TOP);

	// ------------------------------------------------------------------
	// Prescaler
	// ------------------------------------------------------------------
	wire logic [9:0] pre_tc;
	wire logic pre_wrap;
	wire logic timer_tick_enable;
	wire logic tick;

	assign pre_tc = (clock_sel == CS_DIV8) ? PRE_TC_8 :
		(clock_sel == CS_DIV64) ? PRE_TC_64 :
		(clock_sel == CS_DIV256) ? PRE_TC_256 :
		(clock_sel == CS_DIV1024) ? PRE_TC_1024 :
		PRE_RESET;
	assign pre_wrap = pre_count >= pre_tc;
	assign timer_tick_enable = (clock_sel != CS_STOP) && (clock_sel <= CS_DIV1024) &&
		pre_wrap;
	// Only the timer tick advances count and flags, and buffers in the symmetric modes
	assign tick = ce & timer_tick_enable & pfc_mode;

	// ------------------------------------------------------------------
	// Dual-slope counter
	// ------------------------------------------------------------------
	wire logic [WIDTH-1:0] compare_a_active;
	wire logic [WIDTH-1:0] compare_b_active;
	wire logic [WIDTH-1:0] top;
	wire logic at_bottom;
	wire logic at_top;
	wire logic rising;
	wire logic bottom_tick;
	wire logic top_tick;
	wire logic [WIDTH-1:0] next_count;
	wire logic match_a;
	wire logic match_b;

	assign top = (waveform_mode_sel == WGM_PFC_CMP_TOP) ? compare_a_active :
		capture_top_value;
	assign at_bottom = count_value == BOTTOM;
	assign at_top = count_value == top;
	// Going down also covers a count left above a lowered TOP
	assign rising = at_bottom || ((dir == count_up) && (count_value < top));
	assign next_count = rising ? count_value + 1'b1 : count_value - 1'b1;
	assign bottom_tick = tick & at_bottom;
	assign top_tick = tick & at_top;

	// ------------------------------------------------------------------
	// Compare channels
	// ------------------------------------------------------------------
	// Outside the symmetric modes the counter is frozen, so buffers pass straight on
	wire logic reload;
	wire logic wave_out_a;
	wire logic wave_out_b;

	assign reload = bottom_tick | ~pfc_mode;

	compare_channel #(.WIDTH(WIDTH)) channel_a (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.tick(tick),
		.load(reload),
		.buffer_value(compare_a_value),
		.count(count_value),
		.top(top),
		.rising(rising),
		.toggle_allowed(toggle_ok_a),
		.mode_sel(output_mode_sel_a),
		.active_value(compare_a_active),
		.match(match_a),
		.wave(wave_out_a)
	);

	compare_channel #(.WIDTH(WIDTH)) channel_b (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.tick(tick),
		.load(reload),
		.buffer_value(compare_b_value),
		.count(count_value),
		.top(top),
		.rising(rising),
		.toggle_allowed(1'b0),
		.mode_sel(output_mode_sel_b),
		.active_value(compare_b_active),
		.match(match_b),
		.wave(wave_out_b)
	);

	// ------------------------------------------------------------------
	// Flags
	// ------------------------------------------------------------------
	wire logic [7:0] flag_set;
	wire logic [7:0] flag_clr;
	wire logic [7:0] next_flags;
	wire logic [31:0] rd_data;
	wire logic rd_hit;
	wire logic wr_hit;
	wire logic wr_fire;

	assign flag_set[FLAG_OVF] = bottom_tick;
	assign flag_set[FLAG_CMP_A] = match_a |
		(top_tick & (waveform_mode_sel == WGM_PFC_CMP_TOP));
	assign flag_set[FLAG_CMP_B] = match_b;
	assign flag_set[FLAG_CAP] = top_tick & (waveform_mode_sel == WGM_PFC_CAP_TOP);
	assign flag_set[4:3] = 2'h0;
	assign flag_set[7:6] = 2'h0;
	assign flag_clr = (wr_fire && aw_addr_q == ADDR_FLAGS && w_strb_q[0]) ?
		w_data_q[7:0] : 8'h00;
	// A new event beats a clear in the same cycle
	assign next_flags = (flags & ~flag_clr) | flag_set;

	// ------------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------------
	wire logic [31:0] wr_merged;

	assign s_axi_awready = ce & ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready = ce & ~w_held & ~s_axi_bvalid;
	assign s_axi_arready = ce & ~s_axi_rvalid;
	assign wr_fire = ce & aw_held & w_held & ~s_axi_bvalid;
	assign wr_hit = (aw_addr_q == ADDR_CTRL_A) || (aw_addr_q == ADDR_CTRL_B) ||
		(aw_addr_q == ADDR_COUNT) || (aw_addr_q == ADDR_CMP_A) ||
		(aw_addr_q == ADDR_CMP_B) || (aw_addr_q == ADDR_CAP_TOP) ||
		(aw_addr_q == ADDR_FLAGS) || (aw_addr_q == ADDR_PORT);
	assign rd_hit = (s_axi_araddr == ADDR_CTRL_A) || (s_axi_araddr == ADDR_CTRL_B) ||
		(s_axi_araddr == ADDR_COUNT) || (s_axi_araddr == ADDR_CMP_A) ||
		(s_axi_araddr == ADDR_CMP_B) || (s_axi_araddr == ADDR_CAP_TOP) ||
		(s_axi_araddr == ADDR_FLAGS) || (s_axi_araddr == ADDR_PORT);
	assign rd_data = (s_axi_araddr == ADDR_CTRL_A) ? {24'h000000, waveform_output_ctrl_a} :
		(s_axi_araddr == ADDR_CTRL_B) ? {24'h000000, waveform_ctrl_b} :
		(s_axi_araddr == ADDR_COUNT) ? {16'h0000, count_value} :
		(s_axi_araddr == ADDR_CMP_A) ? {16'h0000, compare_a_value} :
		(s_axi_araddr == ADDR_CMP_B) ? {16'h0000, compare_b_value} :
		(s_axi_araddr == ADDR_CAP_TOP) ? {16'h0000, capture_top_value} :
		(s_axi_araddr == ADDR_FLAGS) ? {24'h000000, flags} :
		(s_axi_araddr == ADDR_PORT) ? {28'h0000000, port_ctrl} :
		32'h00000000;

	// Old value of the addressed word, so partial strobes keep untouched bytes
	assign wr_merged = merge(
		(aw_addr_q == ADDR_CTRL_A) ? {24'h000000, waveform_output_ctrl_a} :
		(aw_addr_q == ADDR_CTRL_B) ? {24'h000000, waveform_ctrl_b} :
		(aw_addr_q == ADDR_COUNT) ? {16'h0000, count_value} :
		(aw_addr_q == ADDR_CMP_A) ? {16'h0000, compare_a_value} :
		(aw_addr_q == ADDR_CMP_B) ? {16'h0000, compare_b_value} :
		(aw_addr_q == ADDR_CAP_TOP) ? {16'h0000, capture_top_value} :
		{28'h0000000, port_ctrl},
		w_data_q, w_strb_q);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_data;
				s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Registers and counter
	// ------------------------------------------------------------------
	wire logic wr_ctrl_a;
	wire logic wr_ctrl_b;
	wire logic wr_count;
	wire logic wr_cmp_a;
	wire logic wr_cmp_b;
	wire logic wr_cap;
	wire logic wr_port;

	assign wr_ctrl_a = wr_fire && aw_addr_q == ADDR_CTRL_A;
	assign wr_ctrl_b = wr_fire && aw_addr_q == ADDR_CTRL_B;
	assign wr_count = wr_fire && aw_addr_q == ADDR_COUNT;
	assign wr_cmp_a = wr_fire && aw_addr_q == ADDR_CMP_A;
	assign wr_cmp_b = wr_fire && aw_addr_q == ADDR_CMP_B;
	assign wr_cap = wr_fire && aw_addr_q == ADDR_CAP_TOP;
	assign wr_port = wr_fire && aw_addr_q == ADDR_PORT;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			waveform_output_ctrl_a <= CTRL_A_RESET;
			waveform_ctrl_b <= CTRL_B_RESET;
			compare_a_value <= CMP_RESET;
			compare_b_value <= CMP_RESET;
			capture_top_value <= CAP_RESET;
			port_ctrl <= PORT_RESET;
			flags <= FLAGS_RESET;
		end else if (ce) begin
			flags <= next_flags;
			if (wr_ctrl_a) begin
				waveform_output_ctrl_a <= {wr_merged[7:4], 2'h0, wr_merged[1:0]};
			end
			if (wr_ctrl_b) begin
				waveform_ctrl_b <= {3'h0, wr_merged[4:0]};
			end
			if (wr_cmp_a) begin
				compare_a_value <= wr_merged[WIDTH-1:0];
			end
			if (wr_cmp_b) begin
				compare_b_value <= wr_merged[WIDTH-1:0];
			end
			if (wr_cap) begin
				capture_top_value <= wr_merged[WIDTH-1:0];
			end
			if (wr_port) begin
				port_ctrl <= wr_merged[3:0];
			end
		end
	end

	// A software write to the count takes priority over the tick
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_value <= COUNT_RESET;
			dir <= count_up;
			pre_count <= PRE_RESET;
		end else if (ce) begin
			pre_count <= pre_wrap ? PRE_RESET : pre_count + 1'b1;
			if (wr_count) begin
				count_value <= wr_merged[WIDTH-1:0];
			end else if (tick) begin
				count_value <= next_count;
				dir <= rising ? count_up : count_down;
			end
		end
	end

	// ------------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------------
	wire logic override_a;
	wire logic override_b;

	assign override_a = (output_mode_sel_a != OUT_DISCONNECT) &&
		((output_mode_sel_a != OUT_TOGGLE) || toggle_ok_a);
	assign override_b = (output_mode_sel_b != OUT_DISCONNECT) &&
		(output_mode_sel_b != OUT_TOGGLE);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_a <= 1'b0;
			pin_b <= 1'b0;
			pin_a_oe <= 1'b0;
			pin_b_oe <= 1'b0;
		end else if (ce) begin
			pin_a <= override_a ? wave_out_a : port_ctrl[PORT_LVL_A];
			pin_b <= override_b ? wave_out_b : port_ctrl[PORT_LVL_B];
			pin_a_oe <= port_ctrl[PORT_DIR_A];
			pin_b_oe <= port_ctrl[PORT_DIR_B];
		end
	end

endmodule

`default_nettype wire

// [hdl/pwm_pkg.sv]
// Constants shared by the dual-slope symmetric PWM timer and its compare channels
package pwm_pkg;

	// ------------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL_A = 8'h80;
	localparam logic [7:0] ADDR_CTRL_B = 8'h84;
	localparam logic [7:0] ADDR_COUNT = 8'h88;
	localparam logic [7:0] ADDR_CMP_A = 8'h8C;
	localparam logic [7:0] ADDR_CMP_B = 8'h90;
	localparam logic [7:0] ADDR_CAP_TOP = 8'h94;
	localparam logic [7:0] ADDR_FLAGS = 8'h98;
	localparam logic [7:0] ADDR_PORT = 8'h9C;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int CTRLA_MODE_A_LSB = 6;
	localparam int CTRLA_MODE_B_LSB = 4;
	localparam int CTRLA_WGM_LO_LSB = 0;
	localparam int CTRLB_WGM_HI_LSB = 3;
	localparam int CTRLB_CS_LSB = 0;
	localparam int FLAG_OVF = 0;
	localparam int FLAG_CMP_A = 1;
	localparam int FLAG_CMP_B = 2;
	localparam int FLAG_CAP = 5;
	localparam int PORT_DIR_A = 0;
	localparam int PORT_DIR_B = 1;
	localparam int PORT_LVL_A = 2;
	localparam int PORT_LVL_B = 3;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] CTRL_A_RESET = 8'h00;
	localparam logic [7:0] CTRL_B_RESET = 8'h00;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [3:0] PORT_RESET = 4'h0;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] CMP_RESET = 16'h0000;
	localparam logic [15:0] CAP_RESET = 16'h0000;
	localparam logic [15:0] BOTTOM = 16'h0000;

	// ------------------------------------------------------------------
	// Modes and encodings
	// ------------------------------------------------------------------
	localparam logic [3:0] WGM_PFC_CAP_TOP = 4'h8;
	localparam logic [3:0] WGM_PFC_CMP_TOP = 4'h9;
	localparam logic [3:0] WGM_PC_CMP_TOP = 4'hB;
	localparam logic [1:0] OUT_DISCONNECT = 2'h0;
	localparam logic [1:0] OUT_TOGGLE = 2'h1;
	localparam logic [1:0] OUT_NONINV = 2'h2;
	localparam logic [1:0] OUT_INV = 2'h3;

	// Clock select codes and prescaler terminal counts (divider minus one)
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [9:0] PRE_TC_8 = 10'h007;
	localparam logic [9:0] PRE_TC_64 = 10'h03F;
	localparam logic [9:0] PRE_TC_256 = 10'h0FF;
	localparam logic [9:0] PRE_TC_1024 = 10'h3FF;
	localparam logic [9:0] PRE_RESET = 10'h000;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic {count_up, count_down} dir_t;

endpackage

// [hdl/compare_channel.sv]
// One double-buffered compare channel with its wave output
`timescale 1ns/1ps
`default_nettype none

module compare_channel
	import pwm_pkg::*;
#(
	parameter int WIDTH = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic tick,
	input wire logic load,
	input wire logic [WIDTH-1:0] buffer_value,
	input wire logic [WIDTH-1:0] count,
	input wire logic [WIDTH-1:0] top,
	input wire logic rising,
	input wire logic toggle_allowed,
	input wire logic [1:0] mode_sel,
	output logic [WIDTH-1:0] active_value,
	output logic match,
	output logic wave
);

	wire logic reachable;
	wire logic next_wave;

	// A compare value above TOP is never reached, even after TOP is lowered
	assign reachable = active_value <= top;
	assign match = tick & reachable & (count == active_value);

	// Extremes count as turning points so in non-inverting mode BOTTOM gives low and TOP gives high
	assign next_wave = (mode_sel == OUT_NONINV) ? ~rising :
		(mode_sel == OUT_INV) ? rising :
		(mode_sel == OUT_TOGGLE && toggle_allowed) ? ~wave :
		wave;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			active_value <= CMP_RESET;
			wave <= 1'b0;
		end else if (ce) begin
			if (load) begin
				active_value <= buffer_value;
			end
			if (match) begin
				wave <= next_wave;
			end
		end
	end

endmodule

`default_nettype wire

// [verif/symmetric_pwm_monitor.sv]
// Bus handshake and pin-enable checks for the symmetric PWM timer
`timescale 1ns/1ps
`default_nettype none

module symmetric_pwm_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic pin_a_oe,
	input wire logic pin_b_oe
);
	default clocking mon_cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_bvalid_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped early");
	property p_rvalid_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp});
	endproperty
	a_rvalid_hold: assert property (p_rvalid_hold) else $error("read response dropped early");
	property p_read_latency;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_read_latency: assert property (p_read_latency) else $error("read answer late");
	property p_write_latency;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_write_latency: assert property (p_write_latency) else $error("write answer late");
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken while answer pending");
	property p_aw_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_aw_block: assert property (p_aw_block) else $error("write taken while answer pending");
	property p_aw_taken;
		s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2];
	endproperty
	a_aw_taken: assert property (p_aw_taken) else $error("address channel reopened too soon");
	property p_oe_after_write;
		$changed({pin_a_oe, pin_b_oe}) |->
			s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
	endproperty
	a_oe_after_write: assert property (p_oe_after_write) else $error("pin enable moved alone");
endmodule

bind symmetric_pwm_timer symmetric_pwm_monitor u_monitor (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.pin_a_oe(pin_a_oe), .pin_b_oe(pin_b_oe)
);
`default_nettype wire

// [verif/pwm_load.sv]
// Load on the two PWM pins: resolves pad levels, counts high time of both and rising edges of A
`timescale 1ns/1ps
`default_nettype none

module pwm_load (
	input wire logic aclk,
	input wire logic clr,
	input wire logic pin_a,
	input wire logic pin_a_oe,
	input wire logic pin_b,
	input wire logic pin_b_oe,
	output logic [15:0] hi_a,
	output logic [15:0] hi_b,
	output logic [15:0] rises_a
);
	// Pull-down on the load, so an undriven pad reads low
	wire line_a = pin_a_oe ? pin_a : 1'h0;
	wire line_b = pin_b_oe ? pin_b : 1'h0;
	logic prev_a;

	always_ff @(posedge aclk) begin
		prev_a <= line_a;
		if (clr) begin
			hi_a <= 16'h0000;
			hi_b <= 16'h0000;
			rises_a <= 16'h0000;
		end else begin
			hi_a <= hi_a + {15'h0000, line_a};
			hi_b <= hi_b + {15'h0000, line_b};
			rises_a <= rises_a + {15'h0000, line_a & ~prev_a};
		end
	end
endmodule
`default_nettype wire

// [verif/dual_slope_symmetric_pwm_test.sv]
// Register-level test of the symmetric PWM timer with a pin load model
`timescale 1ns/1ps
`default_nettype none

module dual_slope_symmetric_pwm_test import pwm_pkg::*;;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, clr, ce_in;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid, pin_a, pin_a_oe, pin_b, pin_b_oe;
	logic [15:0] hi_a, hi_b, rises_a;
	int num_errors = 0;
	int tests_run = 0;

	symmetric_pwm_timer DUT (
		.aclk(aclk), .aresetn(aresetn), .ce(ce_in),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.pin_a(pin_a), .pin_a_oe(pin_a_oe), .pin_b(pin_b), .pin_b_oe(pin_b_oe)
	);
	pwm_load LOAD (
		.aclk(aclk), .clr(clr), .pin_a(pin_a), .pin_a_oe(pin_a_oe), .pin_b(pin_b),
		.pin_b_oe(pin_b_oe), .hi_a(hi_a), .hi_b(hi_b), .rises_a(rises_a)
	);

	initial begin
		aclk = 1'h0;
		forever #5 aclk = ~aclk;
	end

	// ------------------------------------------------------------------
	// Compare, bus and measurement tasks
	// ------------------------------------------------------------------
	task automatic check_data(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic check_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Response ready is raised late on purpose, so the hold of each answer is exercised
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic a_ok, w_ok;
		a_ok = 1'h0;
		w_ok = 1'h0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		while (!(a_ok && w_ok)) begin
			@(posedge aclk);
			a_ok = a_ok | (awvalid & awready);
			w_ok = w_ok | (wvalid & wready);
			if (a_ok)
				awvalid <= 1'h0;
			if (w_ok)
				wvalid <= 1'h0;
		end
		repeat (2) @(posedge aclk);
		bready <= 1'h1;
		do @(posedge aclk); while (bvalid !== 1'h1);
		bready <= 1'h0;
		check_resp($sformatf("write resp %h", a), er, bresp);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er,
		input logic [31:0] m = 32'hFFFFFFFF);
		araddr <= a;
		arvalid <= 1'h1;
		do @(posedge aclk); while (arready !== 1'h1);
		arvalid <= 1'h0;
		@(posedge aclk);
		rready <= 1'h1;
		do @(posedge aclk); while (rvalid !== 1'h1);
		rready <= 1'h0;
		check_data($sformatf("read %h", a), exp, rdata & m);
		check_resp($sformatf("read resp %h", a), er, rresp);
	endtask
	// Window spans whole periods so the counts do not depend on phase; FFFF skips high_a
	task automatic measure(input int w, input logic [15:0] ea, input logic [15:0] er,
		input logic [15:0] eb);
		clr <= 1'h1;
		@(posedge aclk);
		clr <= 1'h0;
		// Counts read before this edge's update hold exactly w sampled cycles
		repeat (w + 1) @(posedge aclk);
		if (ea !== 16'hFFFF)
			check_data("high_a", {16'h0000, ea}, {16'h0000, hi_a});
		check_data("rises_a", {16'h0000, er}, {16'h0000, rises_a});
		check_data("high_b", {16'h0000, eb}, {16'h0000, hi_b});
	endtask
	task automatic tally_and_finish();
		$display("Checks run: %0d, mismatches: %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, clr} = 7'h00;
		ce_in = 1'h1;
		{awaddr, araddr, wdata} = 48'h0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		rd_chk(ADDR_CTRL_A, 32'h0, RESP_OKAY);
		rd_chk(ADDR_CTRL_B, 32'h0, RESP_OKAY);
		rd_chk(ADDR_FLAGS, 32'h0, RESP_OKAY);
		wr(ADDR_CTRL_A, 32'hFF, RESP_OKAY);
		rd_chk(ADDR_CTRL_A, 32'hF3, RESP_OKAY);
		wr(8'hA0, 32'h1, RESP_SLVERR);
		rd_chk(8'hA0, 32'h0, RESP_SLVERR);
		wr(ADDR_CAP_TOP, 32'h4, RESP_OKAY);
		wr(ADDR_CMP_A, 32'h1, RESP_OKAY);
		wr(ADDR_CMP_B, 32'h4, RESP_OKAY);
		wr(ADDR_PORT, 32'h3, RESP_OKAY);
		wr(ADDR_CTRL_A, 32'hB0, RESP_OKAY);
		wr(ADDR_CTRL_B, 32'h11, RESP_OKAY);
		repeat (24) @(posedge aclk);
		measure(64, 16'd16, 16'd8, 16'd0);
		rd_chk(ADDR_FLAGS, 32'h27, RESP_OKAY);
		wr(ADDR_CTRL_B, 32'h12, RESP_OKAY);
		repeat (128) @(posedge aclk);
		measure(128, 16'd32, 16'd2, 16'd0);
		wr(ADDR_CTRL_B, 32'h11, RESP_OKAY);
		wr(ADDR_CMP_A, 32'h5, RESP_OKAY);
		rd_chk(ADDR_CMP_A, 32'h5, RESP_OKAY);
		repeat (24) @(posedge aclk);
		wr(ADDR_FLAGS, 32'hFF, RESP_OKAY);
		// Last match before the reload is the falling one, so A is left high
		measure(64, 16'd64, 16'd0, 16'd0);
		rd_chk(ADDR_FLAGS, 32'h0, RESP_OKAY, 32'h2);
		wr(ADDR_CMP_A, 32'h4, RESP_OKAY);
		wr(ADDR_CMP_B, 32'h0, RESP_OKAY);
		wr(ADDR_CAP_TOP, 32'h6, RESP_OKAY);
		wr(ADDR_CTRL_A, 32'h71, RESP_OKAY);
		repeat (32) @(posedge aclk);
		measure(64, 16'd32, 16'd4, 16'd64);
		wr(ADDR_FLAGS, 32'hFF, RESP_OKAY);
		repeat (16) @(posedge aclk);
		rd_chk(ADDR_FLAGS, 32'h07, RESP_OKAY);
		// Clock enable low: the toggling output must stand still
		ce_in <= 1'h0;
		measure(64, 16'hFFFF, 16'd0, 16'd64);
		ce_in <= 1'h1;
		measure(64, 16'd32, 16'd4, 16'd64);
		wr(ADDR_PORT, 32'hD, RESP_OKAY);
		wr(ADDR_CTRL_A, 32'h40, RESP_OKAY);
		repeat (8) @(posedge aclk);
		measure(64, 16'd64, 16'd0, 16'd0);
		check_data("pin_b_oe", 32'h0, {31'h0, pin_b_oe});
		tally_and_finish();
	end

	// Whole sequence takes about 900 cycles; this leaves a wide margin
	initial begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
